// [eec_dev_model.sv]
// Behavioural two-wire serial EEPROM that answers the host under test
`timescale 1ns/100ps
module eec_dev_model #(
	parameter logic [2:0] P_SEL = 3'h5
) (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_wp,
	input wire logic [31:0] i_prog_ns,
	output logic o_pull
);
	import eec_pkg::*;
	// ****************
	// Device state
	// ****************
	logic [7:0] mem [4096];
	logic [7:0] idp [32];
	logic [7:0] sr, ob, hi;
	logic [11:0] cnt;
	logic [3:0] typ;
	logic [12:0] pa [$];
	logic [7:0] pd [$];
	int bn, idx;
	logic act, rd, busy, arm, ak, locked, lk_p;
	// Known contents so that reads have something to compare against
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
		o_pull = 0; act = 0; busy = 0; arm = 0; ak = 0; locked = 0; cnt = 0; bn = 0; idx = 0; rd = 0;
	end
	// Start opens a frame; nothing is heard while programming
	always @(negedge i_sda) if (i_scl === 1'b1 && !busy) begin
		act = 1; bn = 0; idx = 0; rd = 0; o_pull = 0; arm = 0; lk_p = 0;
		pa.delete();
		pd.delete();
	end
	// Stop commits pending bytes only when it falls in the 10th clock
	always @(posedge i_sda) if (i_scl === 1'b1 && act) begin
		act = 0;
		o_pull = 0;
		if (arm) begin
			foreach (pa[k]) if (pa[k][12]) idp[pa[k][4:0]] = pd[k]; else mem[pa[k][11:0]] = pd[k];
			if (lk_p) locked = 1;
			busy = 1;
		end
	end
	// Self-timed program cycle
	always @(posedge busy) begin
		#(i_prog_ns);
		busy = 0;
	end
	// Sample on the rising clock, MSB first; a later clock disarms the stop
	always @(posedge i_scl) if (act) begin
		if (bn < 8) sr = {sr[6:0], i_sda};
		if (bn == 8 && rd && idx > 0 && i_sda === 1'b1) act = 0;
		if (bn > 0) arm = 0;
		bn++;
	end
	// Decode bytes and drive acks and read data on the falling clock
	always @(negedge i_scl) if (act) begin
		if (bn == 8 && !(rd && idx > 0)) begin
			ak = 1;
			case (idx)
				0: begin
					typ = sr[7:4];
					rd = sr[0];
					ak = (typ == TYPE_MEM || typ == TYPE_ID) && sr[3:1] == P_SEL;
				end
				1: hi = sr;
				2: cnt = (typ == TYPE_ID) ? {7'h0, sr[4:0]} : {hi[3:0], sr};
				default: if (typ == TYPE_ID && hi[2:1] == REGION_LOCK) begin
					ak = !locked && sr[1] && !i_wp;
					lk_p = ak;
				end else begin
					ak = !i_wp && !(typ == TYPE_ID && locked);
					if (ak) begin
						pa.push_back({typ == TYPE_ID, cnt});
						pd.push_back(sr);
						cnt[4:0] = cnt[4:0] + 5'h1;
					end
				end
			endcase
			o_pull = ak;
			if (!ak && idx == 0) act = 0;
		end else if (bn == 9) begin
			bn = 0;
			idx++;
			arm = ak && !rd && idx > 3;
			o_pull = 0;
			if (rd) begin
				ob = (typ == TYPE_ID) ? idp[cnt[4:0]] : mem[cnt];
				cnt = cnt + 12'h1;
				o_pull = !ob[7];
			end
		end else if (rd && idx > 0) o_pull = bn < 8 && !ob[3'(7 - bn)];
	end
endmodule : eec_dev_model

// [eec_host.sv]
// Two-wire host that writes, locks and reads a serial EEPROM under Wishbone control
`timescale 1ns/100ps
module eec_host #(
	parameter int P_PROG_CYCLES = eec_pkg::PROG_CYC_DEF
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [eec_pkg::WB_AW-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Two-wire link, open drain
	output logic o_scl_o,
	output logic o_scl_oe_n,
	output logic o_sda_o,
	output logic o_sda_oe_n,
	input wire logic i_sda_i,
	// Protect pin of the device
	output logic o_wp
);
	import eec_pkg::*;
	// **************************************************
	// Declarations
	// **************************************************
	eec_state_t st_q;
	eec_op_t op_q;
	logic [QCNT_W-1:0] qcnt_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [5:0] idx_q, len_q, len_eff, nbytes, nxt_idx;
	logic [8:0] tx_q, rx_q;
	logic [7:0] rdat_q;
	logic [WCNT_W-1:0] wcnt_q;
	logic [2:0] sel_q;
	logic [15:0] addr_q;
	logic [7:0] buf_q [32];
	logic tick_q, sda_s1_q, sda_s2_q, wait_after_q, polling_q, again_q, done_q, anack_q, dnack_q, id_q, poll_q;
	logic wb_req, wb_wr, start_req, busy, last_byte, rx_byte;
	// **************************************************
	// Byte builder and decode
	// **************************************************
	function automatic logic [7:0] tx_byte(input logic [5:0] idx);
		logic [7:0] b;
		b = (op_q == OP_LOCK) ? LOCK_DATA : buf_q[5'(idx - HDR_BYTES)];
		if (idx == 6'h00) begin
			b = {((op_q == OP_WRITE) || (op_q == OP_CURRD && !id_q)) ? TYPE_MEM : TYPE_ID,
				sel_q, op_q == OP_CURRD};
		end else if (idx == 6'h01) begin
			b = (op_q == OP_WRITE) ? addr_q[15:8]
				: {5'h00, (op_q == OP_LOCK) ? REGION_LOCK : REGION_ID, 1'b0};
		end else if (idx == 6'h02) begin
			b = (op_q == OP_WRITE) ? addr_q[7:0] : {3'h0, (op_q == OP_IDWR) ? addr_q[4:0] : 5'h00};
		end
		return b;
	endfunction : tx_byte
	// Bus request, length clamp and transfer size
	always_comb begin
		wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
		wb_wr = wb_req && i_wb_we && i_wb_sel[0];
		busy = st_q != ST_IDLE;
		start_req = wb_wr && i_wb_adr == REG_CTRL && i_wb_dat[CTL_GO] && !busy;
		len_eff = (len_q == 6'h00) ? 6'h01 : ((len_q > PAGE_BYTES) ? PAGE_BYTES : len_q);
		unique case (op_q)
			OP_LOCK: nbytes = LOCK_BYTES;
			OP_CURRD: nbytes = READ_BYTES;
			default: nbytes = HDR_BYTES + len_eff;
		endcase
		nxt_idx = idx_q + 6'h01;
		last_byte = polling_q || (idx_q == nbytes - 6'h01);
		rx_byte = op_q == OP_CURRD && idx_q == 6'h01 && !polling_q;
	end
	// **************************************************
	// Quarter-bit divider and input synchroniser
	// **************************************************
	// One tick per quarter of the link clock period
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			qcnt_q <= '0;
			tick_q <= 1'b0;
		end else if (qcnt_q == QCNT_W'(QTR_CYC - 1)) begin
			qcnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			qcnt_q <= qcnt_q + QCNT_W'(1);
			tick_q <= 1'b0;
		end
	end
	// Data line resynchronised before the sequencer reads it
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else begin
			sda_s1_q <= i_sda_i;
			sda_s2_q <= sda_s1_q;
		end
	end
	// **************************************************
	// Wishbone slave
	// **************************************************
	// Answer every access one cycle after it is presented
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= '0;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= '0;
			if (wb_req && !i_wb_we) begin
				if (i_wb_adr[BUF_SEL_BIT]) begin
					o_wb_dat <= {24'h0, buf_q[i_wb_adr[6:2]]};
				end else begin
					unique case (i_wb_adr)
						REG_CTRL: o_wb_dat <= {22'h0, poll_q, o_wp, id_q, sel_q, 2'h0, op_q};
						REG_ADDR: o_wb_dat <= {16'h0, addr_q};
						REG_LEN: o_wb_dat <= {26'h0, len_q};
						REG_STAT: o_wb_dat <= {28'h0, dnack_q, anack_q, done_q, busy};
						REG_RDAT: o_wb_dat <= {24'h0, rdat_q};
						default: o_wb_dat <= '0;
					endcase
				end
			end
		end
	end
	// Configuration, frozen while a transfer runs
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			op_q <= OP_WRITE;
			sel_q <= 3'h0;
			id_q <= 1'b0;
			o_wp <= 1'b0;
			poll_q <= 1'b0;
			addr_q <= 16'h0000;
			len_q <= 6'h01;
		end else if (wb_wr && !busy) begin
			if (i_wb_adr == REG_CTRL) begin
				op_q <= eec_op_t'(i_wb_dat[CTL_OP_LSB +: 2]);
				sel_q <= i_wb_dat[CTL_SEL_LSB +: 3];
				id_q <= i_wb_dat[CTL_ID];
				o_wp <= i_wb_dat[CTL_WP] && i_wb_sel[1];
				poll_q <= i_wb_dat[CTL_POLL] && i_wb_sel[1];
			end else if (i_wb_adr == REG_ADDR) begin
				addr_q <= {i_wb_sel[1] ? i_wb_dat[15:8] : addr_q[15:8], i_wb_dat[7:0]};
			end else if (i_wb_adr == REG_LEN) begin
				len_q <= i_wb_dat[5:0];
			end
		end
	end
	// Page buffer of outgoing data bytes
	always_ff @(posedge i_clk) begin
		if (wb_wr && !busy && i_wb_adr[BUF_SEL_BIT]) begin
			buf_q[i_wb_adr[6:2]] <= i_wb_dat[7:0];
		end
	end
	// **************************************************
	// Link sequencer
	// **************************************************
	// Start, nine-bit byte slots, stop, then program wait or polling
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= ST_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			idx_q <= 6'h00;
			tx_q <= 9'h1ff;
			rx_q <= 9'h000;
			rdat_q <= 8'h00;
			wait_after_q <= 1'b0;
			polling_q <= 1'b0;
			again_q <= 1'b0;
			done_q <= 1'b0;
			anack_q <= 1'b0;
			dnack_q <= 1'b0;
			wcnt_q <= '0;
			o_scl_o <= 1'b0;
			o_sda_o <= 1'b0;
			o_scl_oe_n <= 1'b1;
			o_sda_oe_n <= 1'b1;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					ph_q <= 2'h0;
					if (start_req) begin
						st_q <= ST_START;
						done_q <= 1'b0;
						anack_q <= 1'b0;
						dnack_q <= 1'b0;
						polling_q <= 1'b0;
						wait_after_q <= 1'b0;
					end
				end
				ST_START: if (tick_q) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: o_sda_oe_n <= 1'b1; // Bus-free quarter, clock line already released
						2'h1: o_sda_oe_n <= 1'b0;
						2'h2: o_scl_oe_n <= 1'b0;
						2'h3: begin
							st_q <= ST_BYTE;
							idx_q <= 6'h00;
							bit_q <= 4'h0;
							tx_q <= {tx_byte(6'h00), 1'b1};
						end
					endcase
				end
				ST_BYTE: if (tick_q) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: o_sda_oe_n <= tx_q[8];
						2'h1: o_scl_oe_n <= 1'b1;
						2'h2: rx_q <= {rx_q[7:0], sda_s2_q};
						2'h3: begin
							o_scl_oe_n <= 1'b0;
							bit_q <= bit_q + 4'h1;
							tx_q <= {tx_q[7:0], 1'b1};
							if (bit_q == LAST_BIT) begin
								if (rx_byte) begin
									rdat_q <= rx_q[8:1];
									st_q <= ST_STOP;
								end else if (rx_q[0]) begin
									again_q <= polling_q;
									anack_q <= anack_q || (!polling_q && idx_q < HDR_BYTES);
									dnack_q <= dnack_q || (!polling_q && idx_q >= HDR_BYTES);
									st_q <= ST_STOP;
								end else if (last_byte) begin
									again_q <= 1'b0;
									wait_after_q <= !polling_q && op_q != OP_CURRD;
									st_q <= ST_STOP;
								end else begin
									idx_q <= nxt_idx;
									bit_q <= 4'h0;
									tx_q <= (op_q == OP_CURRD) ? 9'h1ff : {tx_byte(nxt_idx), 1'b1};
								end
							end
						end
					endcase
				end
				ST_STOP: if (tick_q) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: o_sda_oe_n <= 1'b0;
						2'h1: o_scl_oe_n <= 1'b1;
						2'h2: o_sda_oe_n <= 1'b1;
						2'h3: begin
							if (wait_after_q) begin
								wait_after_q <= 1'b0;
								polling_q <= poll_q;
								wcnt_q <= '0;
								st_q <= ST_WAIT;
							end else if (again_q) begin
								again_q <= 1'b0;
								st_q <= ST_START;
							end else begin
								polling_q <= 1'b0;
								done_q <= 1'b1;
								st_q <= ST_IDLE;
							end
						end
					endcase
				end
				ST_WAIT: begin
					wcnt_q <= wcnt_q + WCNT_W'(1);
					if (polling_q) begin
						st_q <= ST_START;
					end else if (wcnt_q == WCNT_W'(P_PROG_CYCLES - 1)) begin
						done_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// **************************************************
	// Assertions
	// **************************************************
	dev_type_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		($rose(st_q == ST_BYTE) && op_q == OP_WRITE) |-> tx_q[8:5] == TYPE_MEM && tx_q[1] == 1'b0)
		else $error("write address byte has wrong type or direction");
	read_addr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		($rose(st_q == ST_BYTE) && op_q == OP_CURRD && !polling_q)
		|-> tx_q[1] == 1'b1 && tx_q[4:2] == sel_q && tx_q[8:5] == (id_q ? TYPE_ID : TYPE_MEM))
		else $error("read address byte malformed");
	stop_place_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		($rose(st_q == ST_STOP) && wait_after_q) |-> $past(idx_q) == nbytes - 6'h01 && !$past(rx_q[0]))
		else $error("program stop not after last acked data byte");
	page_size_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == ST_BYTE) |-> idx_q <= HDR_BYTES + PAGE_BYTES - 6'h01)
		else $error("more than one page of data sent");
	early_stop_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == ST_BYTE && op_q != OP_CURRD && !polling_q && tick_q && ph_q == 2'h3
			&& bit_q == LAST_BIT && !rx_q[0] && idx_q != nbytes - 6'h01) |=> st_q == ST_BYTE)
		else $error("write ended before last data byte");
	id_region_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == ST_BYTE && op_q == OP_IDWR && idx_q == 6'h01 && bit_q == 4'h0 && ph_q == 2'h0)
		|-> tx_q[3:2] == REGION_ID && tx_q[8:6] == 3'h0)
		else $error("identification write region not 00");
	lock_data_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == ST_BYTE && op_q == OP_LOCK && idx_q == 6'h03 && bit_q == 4'h0 && ph_q == 2'h0)
		|-> tx_q[2] == 1'b1)
		else $error("lock data bit one clear");
	read_nack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == ST_BYTE && rx_byte && bit_q == LAST_BIT && ph_q == 2'h1) |-> o_sda_oe_n == 1'b1)
		else $error("read byte not answered with nack");
	prog_wait_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == ST_WAIT && !polling_q ##1 st_q == ST_IDLE) |-> $past(wcnt_q) == WCNT_W'(P_PROG_CYCLES - 1))
		else $error("program wait ended early");
endmodule : eec_host

// [eec_host_test.sv]
// Self-checking bench for the two-wire EEPROM host against a device model
`timescale 1ns/100ps
module eec_host_test;
	import eec_pkg::*;
	// ****************
	// Bench wiring
	// ****************
	localparam logic [2:0] DEV_SEL = 3'h5;
	logic i_clk, i_nrst, cyc, stb, we, ack, scl_oe_n, sda_oe_n, scl_o, sda_o, wp, dpull;
	logic [7:0] adr;
	logic [7:0] d [3];
	logic [11:0] a;
	logic [31:0] wdat, rdat, st, q, prog_ns;
	int fails, num_checks;
	// Open-drain lines with pull-ups: low only where an enabled driver or the device pulls
	wire logic scl = scl_oe_n | scl_o;
	wire logic sda = (sda_oe_n | sda_o) & ~dpull;
	eec_host #(.P_PROG_CYCLES(50)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_sda_i(sda), .o_wp(wp));
	eec_dev_model #(.P_SEL(DEV_SEL)) dev (.i_scl(scl), .i_sda(sda), .i_wp(wp), .i_prog_ns(prog_ns), .o_pull(dpull));
	// Initial device contents
	function automatic logic [7:0] pat(input logic [11:0] x);
		return x[7:0] ^ 8'h5a;
	endfunction : pat
	// Control word with go set
	function automatic logic [31:0] cw(input logic [1:0] o, input logic [2:0] s, input logic w, input logic p);
		return {22'h0, p, w, 1'b0, s, 1'b0, 1'b1, o};
	endfunction : cw
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Classic Wishbone single access, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt, output logic [31:0] rq);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= dt;
		@(posedge i_clk);
		while (ack !== 1'b1) @(posedge i_clk);
		rq = rdat;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge i_clk);
	endtask : wb
	// Load address and length, launch, then poll status until idle; a hang is left to the watchdog
	task automatic op(input logic [31:0] ctl, input logic [15:0] ad, input logic [31:0] len);
		wb(1'b1, REG_ADDR, {16'h0, ad}, q);
		wb(1'b1, REG_LEN, len, q);
		wb(1'b1, REG_CTRL, ctl, q);
		do begin
			wb(1'b0, REG_STAT, 32'h0, st);
		end while (st[STA_BUSY] !== 1'b0);
	endtask : op
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		i_clk = 0;
		forever #2 i_clk = ~i_clk;
	end
	// Watchdog: the sequence needs about 35 link bytes of 1 us clocks
	initial begin
		#420000;
		fails++;
		close_out();
	end
	initial begin
		i_nrst = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; fails = 0; num_checks = 0; prog_ns = 150;
		void'($urandom(94));
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		// Page write across the page end, slow device, ack polling
		for (int i = 0; i < 3; i++) begin
			d[i] = 8'($urandom);
			wb(1'b1, 8'h80 + 8'(4 * i), {24'h0, d[i]}, q);
		end
		prog_ns = 30000;
		op(cw(OP_WRITE, DEV_SEL, 1'b0, 1'b1), 16'h0ffe, 32'd3);
		chk(st[3:0], 4'h2);
		chk({dev.mem[12'hffe], dev.mem[12'hfff], dev.mem[12'hfe0]}, {8'h0, d[0], d[1], d[2]});
		prog_ns = 150;
		// Current read with protect high follows the wrapped counter
		op(cw(OP_CURRD, DEV_SEL, 1'b1, 1'b0), 16'h0, 32'd1);
		wb(1'b0, REG_RDAT, 32'h0, q);
		chk({st[3:0], q[7:0]}, {4'h2, pat(12'hfe1)});
		// Protected write is refused and leaves memory alone
		a = 12'($urandom) & 12'h7ff;
		wb(1'b1, 8'h80, {24'h0, ~pat(a)}, q);
		op(cw(OP_WRITE, DEV_SEL, 1'b1, 1'b0), {4'h0, a}, 32'd1);
		chk({st[3:0], dev.mem[a]}, {4'ha, pat(a)});
		wb(1'b0, REG_CTRL, 32'h0, q);
		chk(q, cw(OP_WRITE, DEV_SEL, 1'b1, 1'b0) & ~(32'h1 << CTL_GO));
		// Wrong select bits
		op(cw(OP_WRITE, ~DEV_SEL, 1'b0, 1'b0), 16'h0, 32'd1);
		chk(st[3:0], 4'h6);
		// Identification page write, then the shared counter steers an array read
		a = 12'($urandom) & 12'h01e;
		d[0] = 8'($urandom);
		wb(1'b1, 8'h80, {24'h0, d[0]}, q);
		op(cw(OP_IDWR, DEV_SEL, 1'b0, 1'b0), {4'hf, a}, 32'd1);
		chk({st[3:0], dev.idp[a[4:0]]}, {4'h2, d[0]});
		op(cw(OP_CURRD, DEV_SEL, 1'b0, 1'b0), 16'h0, 32'd1);
		wb(1'b0, REG_RDAT, 32'h0, q);
		chk(q[7:0], pat(a + 12'h1));
		// Lock, then the page and a second lock are refused
		op(cw(OP_LOCK, DEV_SEL, 1'b0, 1'b0), 16'h0, 32'd1);
		chk(st[3:0], 4'h2);
		wb(1'b1, 8'h80, {24'h0, ~d[0]}, q);
		op(cw(OP_IDWR, DEV_SEL, 1'b0, 1'b0), {4'h0, a}, 32'd1);
		chk({st[3:0], dev.idp[a[4:0]]}, {4'ha, d[0]});
		op(cw(OP_LOCK, DEV_SEL, 1'b0, 1'b0), 16'h0, 32'd1);
		chk(st[3:0], 4'ha);
		close_out();
	end
endmodule : eec_host_test

// [eec_pkg.sv]
// Constants, field layout and types for the serial EEPROM host controller
package eec_pkg;
	// **************************************************
	// Timing
	// **************************************************
	localparam int CLK_NS = 4;
	localparam int SCL_PERIOD_NS = 1000;
	localparam int SCL_QTR_NS = SCL_PERIOD_NS / 4;
	localparam int QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam int QCNT_W = 8;
	localparam int PROG_TIME_NS = 5000000;
	localparam int PROG_CYC_DEF = PROG_TIME_NS / CLK_NS;
	localparam int WCNT_W = 21;

	// **************************************************
	// Register map (byte addresses)
	// **************************************************
	localparam int WB_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_LEN = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_RDAT = 8'h10;
	localparam int BUF_SEL_BIT = 7;

	// Control fields
	localparam int CTL_OP_LSB = 0;
	localparam int CTL_GO = 2;
	localparam int CTL_SEL_LSB = 4;
	localparam int CTL_ID = 7;
	localparam int CTL_WP = 8;
	localparam int CTL_POLL = 9;

	// Status fields
	localparam int STA_BUSY = 0;
	localparam int STA_DONE = 1;
	localparam int STA_ANACK = 2;
	localparam int STA_DNACK = 3;

	// **************************************************
	// Protocol codes
	// **************************************************
	localparam logic [3:0] TYPE_MEM = 4'ha;
	localparam logic [3:0] TYPE_ID = 4'hb;
	localparam logic [1:0] REGION_ID = 2'h0;
	localparam logic [1:0] REGION_LOCK = 2'h2;
	localparam logic [7:0] LOCK_DATA = 8'h02;
	localparam logic [5:0] PAGE_BYTES = 6'h20;
	localparam logic [5:0] HDR_BYTES = 6'h03;
	localparam logic [5:0] LOCK_BYTES = 6'h04;
	localparam logic [5:0] READ_BYTES = 6'h02;
	localparam logic [3:0] LAST_BIT = 4'h8;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_IDWR = 2'h1,
		OP_LOCK = 2'h2,
		OP_CURRD = 2'h3
	} eec_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_BYTE = 3'h2,
		ST_STOP = 3'h3,
		ST_WAIT = 3'h4
	} eec_state_t;
endpackage : eec_pkg
